// ### common/mocor_defines.vh
`ifndef MOCOR_DEFINES_VH
`define MOCOR_DEFINES_VH
// ==========================================================
// offset word layout
`define MOCOR_HUM_SIGN_BIT   15
`define MOCOR_HUM_MAG_HI     14
`define MOCOR_HUM_MAG_LO     8
`define MOCOR_TEMP_SIGN_BIT  7
`define MOCOR_TEMP_MAG_HI    6
`define MOCOR_TEMP_MAG_LO    0
// ==========================================================
// magnitude alignment inside the 16-bit result codes
`define MOCOR_HUM_SHIFT      7
`define MOCOR_TEMP_SHIFT     6
// ==========================================================
// factory default offset word (zero magnitudes, subtract signs)
`define MOCOR_OFFSET_RESET   16'h0000
`define MOCOR_CODE_MAX       16'hFFFF
`define MOCOR_CODE_ZERO      16'h0000
`endif

// ### hw/mocor_word_store.v
`timescale 1ns/1ns
`default_nettype none
`include "mocor_defines.vh"
// ==========================================================
// offset word store: commits only on a checked write
module mocor_word_store
#(
   parameter WIDTH = 16
)
(
   // clock and reset
   input  wire             ref_clk,
   input  wire             nrst,
   // write side
   input  wire             wr_en,
   input  wire [WIDTH-1:0] wr_data,
   // read side
   output reg  [WIDTH-1:0] rd_data
);

   // ==========================================================
   // storage register doubles as the registered read port
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         rd_data <= `MOCOR_OFFSET_RESET;
      else if (wr_en)
         rd_data <= wr_data;
   end

endmodule // mocor_word_store
`default_nettype wire

// ### hw/mocor_offset_correct.v
`timescale 1ns/1ns
`default_nettype none
`include "mocor_defines.vh"
module mocor_offset_correct
#(
   parameter WIDTH = 16
)
(
   // clock and reset
   input  wire             ref_clk,
   input  wire             nrst,
   // offset write from the command decoder, check byte already compared
   input  wire             wr_valid,
   input  wire [WIDTH-1:0] wr_word,
   input  wire             wr_crc_ok,
   // raw measurement results, one-cycle valid strobe
   input  wire             meas_valid,
   input  wire [WIDTH-1:0] hum_raw,
   input  wire [WIDTH-1:0] temp_raw,
   // corrected results
   output reg              res_valid,
   output reg  [WIDTH-1:0] hum_out,
   output reg  [WIDTH-1:0] temp_out,
   // write answer to the command decoder
   output reg              wr_ack,
   output reg              wr_nack,
   // readback of the stored offset word
   output wire [WIDTH-1:0] offset_word
);

   // ==========================================================
   // offset word store
   wire             store_en;
   wire             wr_bad;
   wire [WIDTH-1:0] word_q;

   // only a write whose check byte matched may reach the store
   assign store_en = wr_valid & wr_crc_ok;
   // a mismatched check byte is answered and otherwise ignored
   assign wr_bad   = wr_valid & ~wr_crc_ok;

   mocor_word_store #(.WIDTH(WIDTH)) u_store
   (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .wr_en   (store_en),
      .wr_data (wr_word),
      .rd_data (word_q)
   );

   // readback straight from the store register
   assign offset_word = word_q;

   // ==========================================================
   // channel layout shared by both correction paths
   localparam NCH      = 2;
   localparam MAG_BITS = `MOCOR_HUM_MAG_HI - `MOCOR_HUM_MAG_LO + 1;
   localparam CH_HUM   = 0;
   localparam CH_TEMP  = 1;

   // raw codes and corrected codes, one slice per channel
   wire [NCH*WIDTH-1:0] raw_bus;
   wire [NCH*WIDTH-1:0] nxt_bus;
   wire [WIDTH-1:0]     hum_nxt;
   wire [WIDTH-1:0]     temp_nxt;

   // each channel sees only its own raw code, so humidity never meets temperature
   assign raw_bus = {temp_raw, hum_raw};

   // ==========================================================
   // per-channel correction: align, add or subtract, clamp (humidity only)
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch = ch + 1)
      begin : g_chan
         // field positions for this channel
         localparam SIGN_BIT = (ch == CH_HUM) ? `MOCOR_HUM_SIGN_BIT : `MOCOR_TEMP_SIGN_BIT;
         localparam MAG_LO   = (ch == CH_HUM) ? `MOCOR_HUM_MAG_LO   : `MOCOR_TEMP_MAG_LO;
         localparam SHIFT    = (ch == CH_HUM) ? `MOCOR_HUM_SHIFT    : `MOCOR_TEMP_SHIFT;
         // only humidity has end stops; temperature wraps as plain code arithmetic
         localparam CLAMP    = (ch == CH_HUM) ? 1 : 0;

         wire                sign;
         wire [MAG_BITS-1:0] mag;
         wire [WIDTH:0]      step;
         wire [WIDTH-1:0]    raw;
         wire [WIDTH:0]      sum;
         wire [WIDTH:0]      dif;
         wire                over;
         wire                under;
         reg  [WIDTH-1:0]    cor;

         // sign sits above its magnitude in each byte of the stored word
         assign sign = word_q[SIGN_BIT];
         assign mag  = word_q[MAG_LO +: MAG_BITS];

         // magnitude lands on its code weights; all ones gives the largest step
         assign step = {{(WIDTH+1-MAG_BITS){1'h0}}, mag} << SHIFT;

         // raw code of this channel only
         assign raw = raw_bus[ch*WIDTH +: WIDTH];

         // one guard bit catches both the carry out and the borrow
         assign sum = {1'h0, raw} + step;
         assign dif = {1'h0, raw} - step;

         // end stops apply to humidity only
         assign over  = (CLAMP != 0) & sum[WIDTH];
         assign under = (CLAMP != 0) & dif[WIDTH];

         // sign one adds, sign zero subtracts
         always @*
         begin
            if (sign)
            begin
               if (over)
                  cor = `MOCOR_CODE_MAX;
               else
                  cor = sum[WIDTH-1:0];
            end
            else
            begin
               if (under)
                  cor = `MOCOR_CODE_ZERO;
               else
                  cor = dif[WIDTH-1:0];
            end
         end

         // pack this channel's corrected code
         assign nxt_bus[ch*WIDTH +: WIDTH] = cor;
      end
   endgenerate

   // ==========================================================
   // unpack corrected codes
   assign hum_nxt  = nxt_bus[CH_HUM*WIDTH +: WIDTH];
   assign temp_nxt = nxt_bus[CH_TEMP*WIDTH +: WIDTH];

   // ==========================================================
   // result strobe: one cycle behind the raw strobe
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         res_valid <= 1'h0;
      end
      else
      begin
         res_valid <= meas_valid;
      end
   end

   // corrected humidity holds until the next measurement
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hum_out <= `MOCOR_CODE_ZERO;
      end
      else if (meas_valid)
      begin
         hum_out <= hum_nxt;
      end
   end

   // corrected temperature holds until the next measurement
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         temp_out <= `MOCOR_CODE_ZERO;
      end
      else if (meas_valid)
      begin
         temp_out <= temp_nxt;
      end
   end

   // ==========================================================
   // write answer: exactly one of ack or nack per write request
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_ack <= 1'h0;
      end
      else
      begin
         wr_ack <= store_en;
      end
   end

   // refused writes leave the store alone but still get an answer
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_nack <= 1'h0;
      end
      else
      begin
         wr_nack <= wr_bad;
      end
   end

endmodule // mocor_offset_correct
`default_nettype wire

// ### testbench/mocor_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// port checker for offset correction
module mocor_chk (
   // clock, reset, strobes
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        wr_valid,
   input wire logic        wr_crc_ok,
   input wire logic        meas_valid,
   input wire logic        res_valid,
   input wire logic        wr_ack,
   input wire logic        wr_nack,
   // words
   input wire logic [15:0] wr_word,
   input wire logic [15:0] hum_raw,
   input wire logic [15:0] temp_raw,
   input wire logic [15:0] hum_out,
   input wire logic [15:0] temp_out,
   input wire logic [15:0] offset_word
);
   // expected results from the stored word; 17 bits keep the carry for saturation
   wire [16:0] m  = {3'h0, offset_word[14:8], 7'h0};
   wire [16:0] up = hum_raw + m;
   wire [16:0] dn = hum_raw - m;
   wire [15:0] tm = {3'h0, offset_word[6:0], 6'h0};
   wire [15:0] hx = offset_word[15] ? (up[16] ? 16'hFFFF : up[15:0])
                                    : (dn[16] ? 16'h0000 : dn[15:0]);
   wire [15:0] tx = offset_word[7] ? temp_raw + tm : temp_raw - tm;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_good_write: assert property (wr_valid && wr_crc_ok |=>
      wr_ack && offset_word == $past(wr_word)) else $error("write lost");
   a_bad_write: assert property (wr_valid && !wr_crc_ok |=>
      wr_nack && !wr_ack && $stable(offset_word)) else $error("bad write taken");
   a_word_hold: assert property (!wr_valid |=>
      !wr_ack && !wr_nack && $stable(offset_word)) else $error("word moved");
   a_reset_zero: assert property ($rose(nrst) |->
      offset_word == 16'h0000 && hum_out == 16'h0000) else $error("reset word");
   a_hum_math: assert property (meas_valid |=>
      res_valid && hum_out == $past(hx)) else $error("humidity");
   a_temp_math: assert property (meas_valid |=>
      temp_out == $past(tx)) else $error("temperature");
   a_floor_zero: assert property (meas_valid && !offset_word[15] && dn[16] |=>
      hum_out == 16'h0000) else $error("no floor");
   a_hum_ceiling: assert property (meas_valid && offset_word[15] && up[16] |=>
      hum_out == 16'hFFFF) else $error("no ceiling");
endmodule // mocor_chk
bind mocor_offset_correct mocor_chk chk_i (.ref_clk, .nrst, .wr_valid, .wr_crc_ok, .meas_valid,
   .res_valid, .wr_ack, .wr_nack, .wr_word, .hum_raw, .temp_raw, .hum_out, .temp_out, .offset_word);
`default_nettype wire

// ### testbench/mocor_host.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// host side: one offset word per write, check verdict as a flag
module mocor_host #(
   // quiet cycles after a write; stands in for the millisecond pauses, cut to a few cycles to keep the run short
   parameter int IDLE_CYC = 4
) (
   // clock
   input  wire logic        ref_clk,
   // write request
   output var  logic        wr_valid,
   output var  logic        wr_crc_ok,
   output var  logic [15:0] wr_word
);
   initial {wr_valid, wr_crc_ok, wr_word} = 18'h0;
   // two data bytes plus check byte; ok low stands for a wrong check byte
   task put(input logic [15:0] w, input logic ok);
      @(posedge ref_clk);
      {wr_valid, wr_crc_ok, wr_word} <= {1'h1, ok, w};
      @(posedge ref_clk);
      // released lines show the inverse so a stale word is never mistaken
      {wr_valid, wr_crc_ok, wr_word} <= {1'h0, ~ok, ~w};
   endtask
   // no traffic toward the device until its store has settled
   task settle;
      repeat (IDLE_CYC) @(posedge ref_clk);
   endtask
endmodule // mocor_host
`default_nettype wire

// ### testbench/mocor_offset_correct_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mocor_offset_correct_tb;
   logic        ref_clk = 1'h0;
   logic        nrst, meas_valid, wr_valid, wr_crc_ok, res_valid, wr_ack, wr_nack;
   logic [15:0] wr_word, hum_raw, temp_raw, hum_out, temp_out, offset_word, cur;
   int          fail_count = 0;
   int          tests_run = 0;
   // magnitude patterns: one step, top bit, alternating, all ones, both signs
   logic [7:0]  tab [8] = '{8'h81, 8'h01, 8'hC0, 8'h40, 8'hAA, 8'h2A, 8'hFF, 8'h7F};
   initial forever #5 ref_clk = ~ref_clk;
   mocor_host host (.ref_clk, .wr_valid, .wr_crc_ok, .wr_word);
   mocor_offset_correct uut (.ref_clk, .nrst, .wr_valid, .wr_word, .wr_crc_ok, .meas_valid,
      .hum_raw, .temp_raw, .res_valid, .hum_out, .temp_out, .wr_ack, .wr_nack, .offset_word);
   task chk(input logic [15:0] g, e);
      tests_run++;
      fail_count += (g !== e);
      if (g !== e) $display("ERROR %0t got %h want %h", $time, g, e);
   endtask
   task print_verdict;
      if (fail_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // humidity clamps at both ends, temperature wraps
   function logic [15:0] eh(input logic [15:0] r, w);
      logic [16:0] m;
      m = {3'h0, w[14:8], 7'h0};
      if (w[15]) return ({1'h0, r} + m > 17'hFFFF) ? 16'hFFFF : r + m[15:0];
      return (r < m) ? 16'h0000 : r - m[15:0];
   endfunction
   function logic [15:0] et(input logic [15:0] t, w);
      return w[7] ? t + {w[6:0], 6'h0} : t - {w[6:0], 6'h0};
   endfunction
   task wr(input logic [15:0] w, input logic ok);
      host.put(w, ok);
      #1 chk({14'h0, wr_ack, wr_nack}, ok ? 16'h0002 : 16'h0001);
      host.settle;
      chk(offset_word, ok ? w : cur);
      if (ok) cur = w;
   endtask
   task meas(input logic [15:0] h, t);
      @(posedge ref_clk);
      {meas_valid, hum_raw, temp_raw} <= {1'h1, h, t};
      @(posedge ref_clk);
      {meas_valid, hum_raw, temp_raw} <= {1'h0, ~h, ~t};
      #1 chk({15'h0, res_valid}, 16'h0001);
      chk(hum_out, eh(h, cur));
      chk(temp_out, et(t, cur));
   endtask
   task t_default;
      chk(offset_word, 16'h0000);
      meas(16'h1234, 16'h5678);
   endtask
   task t_table;
      for (int i = 0; i < 8; i++)
      begin
         wr({tab[i], tab[7 - i]}, 1'h1);
         meas(16'h8000, 16'h1000);
      end
   endtask
   task t_limits;
      wr(16'h7F00, 1'h1);
      meas(16'h0100, 16'h0000);
      wr(16'hFF00, 1'h1);
      meas(16'hF000, 16'h0000);
      wr(16'hFFFF, 1'h1);
      meas(16'h8000, 16'h0000);
   endtask
   // reset in mid-run after a full-scale offset: word and humidity result return to zero
   task t_reset;
      @(posedge ref_clk);
      nrst <= 1'h0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'h1;
      #1 chk(offset_word, 16'h0000);
      chk(hum_out, 16'h0000);
      cur = 16'h0000;
      meas(16'h1234, 16'h5678);
   endtask
   task t_refuse;
      wr(16'h1234, 1'h0);
      meas(16'h4000, 16'h4000);
   endtask
   initial
   begin
      {nrst, meas_valid, hum_raw, temp_raw} = 34'h0;
      cur = 16'h0000;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'h1;
      t_default;
      t_table;
      t_limits;
      t_reset;
      t_refuse;
      print_verdict;
   end
   // hang guard
   initial
   begin
      #20000 fail_count++;
      print_verdict;
   end
endmodule // mocor_offset_correct_tb
`default_nettype wire
